// ### logic/iis_bcd_add.sv
// packed decimal adder, one digit stage per generate step
`timescale 1ns/1ns
module iis_bcd_add #(
  parameter int DIGITS = 2
) (
  input wire logic [4*DIGITS-1:0] i_a,
  input wire logic [4*DIGITS-1:0] i_b,
  input wire logic i_carry,
  output logic [4*DIGITS-1:0] o_sum,
  output logic o_carry
);
  logic [DIGITS:0] cy;
  assign cy[0] = i_carry;
  // each digit corrects by six once it passes nine
  for (genvar g = 0; g < DIGITS; g++) begin : g_dig
    logic [4:0] raw;
    logic adj;
    assign raw = {1'b0, i_a[4*g+:4]} + {1'b0, i_b[4*g+:4]} + {4'h0, cy[g]};
    assign adj = raw > 5'h09;
    assign o_sum[4*g+:4] = adj ? 4'(raw + 5'h06) : raw[3:0];
    assign cy[g+1] = adj;
  end
  assign o_carry = cy[DIGITS];
endmodule

// ### logic/iis_cond_test.sv
// evaluates one of sixteen branch conditions against the flags
`timescale 1ns/1ns
`include "iis_defines.svh"
module iis_cond_test
  import iis_pkg::*;
(
  input wire logic [3:0] i_cond,
  input wire logic [4:0] i_flags,
  output logic o_true
);
  logic n;
  logic z;
  logic v;
  logic c;
  assign n = i_flags[`IIS_CC_N];
  assign z = i_flags[`IIS_CC_Z];
  assign v = i_flags[`IIS_CC_V];
  assign c = i_flags[`IIS_CC_C];
  // signed tests combine negative and overflow
  always_comb begin
    case (iis_cond_t'(i_cond))
      CC_T: o_true = 1'b1;
      CC_F: o_true = 1'b0;
      CC_HI: o_true = ~c & ~z;
      CC_LS: o_true = c | z;
      CC_CC: o_true = ~c;
      CC_CS: o_true = c;
      CC_NE: o_true = ~z;
      CC_EQ: o_true = z;
      CC_VC: o_true = ~v;
      CC_VS: o_true = v;
      CC_PL: o_true = ~n;
      CC_MI: o_true = n;
      CC_GE: o_true = n ~^ v;
      CC_LT: o_true = n ^ v;
      CC_GT: o_true = ~z & (n ~^ v);
      CC_LE: o_true = z | (n ^ v);
      default: o_true = 1'b0;
    endcase
  end
endmodule

// ### logic/iis_core.sv
// instruction execution unit with wishbone registers and stack cycles
//
// The Wishbone register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "iis_defines.svh"
module iis_core
  import iis_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  input wire logic I_CE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_EXT_REQ,
  output logic [1:0] O_EXT_KIND,
  output logic [31:0] O_EXT_ADDR,
  output logic [31:0] O_EXT_DATA,
  input wire logic I_EXT_ACK,
  input wire logic [31:0] I_EXT_DATA,
  output logic O_ENTER_BACKGROUND,
  output logic O_IRQ
);
  iis_state_t state;
  iis_op_t op_sel;
  logic [3:0] cond_sel;
  logic [31:0] src, dst, imm, pc, user_stack_pointer;
  logic [31:0] supervisor_stack_pointer, addr_x, addr_y, vec_base;
  logic [15:0] status_word;
  logic bg_en, exc;
  logic [1:0] step;
  logic [7:0] vec;
  logic [2:0] int_stat, int_mask;
  logic wr_en, wr_ok, go, do_exec, ack_in, busy, sbit, cc_true;
  logic add_v, sub_v, bitv, bcd_c, need_trap, ev_trap, ev_done, ev_bg;
  logic [31:0] sp_act, add_a, bmask, next_dst, rdata, req_addr, req_data;
  logic [32:0] add_r, sub_r;
  logic [7:0] bcd_sum, trap_vec;
  logic [4:0] next_cc;
  iis_ext_t req_kind;

  // byte lanes a write may touch
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i+:8] = I_WB_DAT[8*i+:8];
      end
    end
    return r;
  endfunction

  // writes take effect on the edge that sees ack; setup is locked while busy
  assign busy = state != ST_IDLE;
  assign wr_en = I_WB_CYC & I_WB_STB & I_WB_WE & O_WB_ACK & I_CE;
  assign wr_ok = wr_en & ~busy;
  assign go = wr_ok & (I_WB_ADR == `IIS_R_CTRL) & I_WB_SEL[2]
              & I_WB_DAT[`IIS_CTRL_GO] & ~O_ENTER_BACKGROUND;
  assign do_exec = (state == ST_EXEC) & I_CE;
  assign ack_in = (state == ST_WAIT) & I_EXT_ACK & I_CE;
  assign sbit = status_word[`IIS_SW_S];
  assign sp_act = sbit ? supervisor_stack_pointer : user_stack_pointer;

  // shared adder and subtractor for the arithmetic and compare ops
  assign add_a = (op_sel inside {OP_ADD_EXT, OP_ADD_EXT_MEM}) ? src : imm;
  assign add_r = {1'b0, add_a} + {1'b0, dst}
                 + {32'h0, (op_sel inside {OP_ADD_EXT, OP_ADD_EXT_MEM})
                           & status_word[`IIS_CC_X]};
  assign add_v = (add_a[31] == dst[31]) & (add_r[31] != dst[31]);
  assign sub_r = {1'b0, dst} - {1'b0, src};
  assign sub_v = (dst[31] != src[31]) & (sub_r[31] != dst[31]);
  // register destination, so the bit number wraps modulo 32
  assign bmask = 32'h1 << imm[4:0];
  assign bitv = |(dst & bmask);

  iis_bcd_add #(.DIGITS(2)) u_bcd (
    .i_a(src[7:0]),
    .i_b(dst[7:0]),
    .i_carry(status_word[`IIS_CC_X]),
    .o_sum(bcd_sum),
    .o_carry(bcd_c)
  );

  iis_cond_test u_cond (
    .i_cond(cond_sel),
    .i_flags(status_word[4:0]),
    .o_true(cc_true)
  );

  // trap decision at execute
  always_comb begin
    need_trap = 1'b0;
    trap_vec = `IIS_VEC_ILLEGAL;
    case (op_sel)
      OP_AND_STATUS: begin
        need_trap = ~sbit;
        trap_vec = `IIS_VEC_PRIV;
      end
      OP_BACKGROUND: need_trap = ~bg_en;
      OP_BOUND: begin
        need_trap = dst[31] | ($signed(dst) > $signed(src));
        trap_vec = `IIS_VEC_BOUND;
      end
      OP_BOUND2: begin
        need_trap = ($signed(dst) < $signed(src))
                    | ($signed(dst) > $signed(imm));
        trap_vec = `IIS_VEC_BOUND;
      end
      default: need_trap = 1'b0;
    endcase
  end

  // new flags and destination value per operation
  always_comb begin
    next_cc = status_word[4:0];
    next_dst = dst;
    case (op_sel)
      OP_ADD_IMM, OP_ADD_QUICK, OP_ADD_EXT, OP_ADD_EXT_MEM: begin
        next_dst = add_r[31:0];
        next_cc[`IIS_CC_X] = add_r[32];
        next_cc[`IIS_CC_C] = add_r[32];
        next_cc[`IIS_CC_N] = add_r[31];
        next_cc[`IIS_CC_V] = add_v;
        // extended forms only clear zero, so multi-word sums chain
        next_cc[`IIS_CC_Z] = (add_r[31:0] == 32'h0)
          & ((op_sel inside {OP_ADD_IMM, OP_ADD_QUICK})
             | status_word[`IIS_CC_Z]);
      end
      OP_DEC_ADD, OP_DEC_ADD_MEM: begin
        next_dst = {dst[31:8], bcd_sum};
        next_cc[`IIS_CC_X] = bcd_c;
        next_cc[`IIS_CC_C] = bcd_c;
        next_cc[`IIS_CC_Z] = status_word[`IIS_CC_Z] & (bcd_sum == 8'h00);
      end
      OP_BIT_CHG, OP_BIT_CLR, OP_BIT_SET, OP_BIT_TEST: begin
        next_cc[`IIS_CC_Z] = ~bitv;
        if (op_sel == OP_BIT_CHG) begin
          next_dst = dst ^ bmask;
        end else if (op_sel == OP_BIT_CLR) begin
          next_dst = dst & ~bmask;
        end else if (op_sel == OP_BIT_SET) begin
          next_dst = dst | bmask;
        end
      end
      OP_COMPARE, OP_MEM_COMPARE: begin
        next_cc[`IIS_CC_N] = sub_r[31];
        next_cc[`IIS_CC_Z] = sub_r[31:0] == 32'h0;
        next_cc[`IIS_CC_V] = sub_v;
        next_cc[`IIS_CC_C] = sub_r[32];
      end
      default: next_cc = status_word[4:0];
    endcase
  end

  // outgoing cycle: exception stack frame, subroutine push or acknowledge
  always_comb begin
    req_kind = EXT_PUSH_L;
    req_addr = sp_act - `IIS_STEP_L;
    req_data = pc;
    if (exc) begin
      case (step)
        2'h0: begin
          req_kind = EXT_PUSH_W;
          req_addr = supervisor_stack_pointer - `IIS_STEP_W;
          req_data = {16'h0, `IIS_FMT, 2'b00, vec, 2'b00};
        end
        2'h1: begin
          req_addr = supervisor_stack_pointer - `IIS_STEP_L;
        end
        2'h2: begin
          req_kind = EXT_PUSH_W;
          req_addr = supervisor_stack_pointer - `IIS_STEP_W;
          req_data = {16'h0, status_word};
        end
        default: begin
          req_kind = EXT_VEC_RD;
          req_addr = vec_base + {22'h0, vec, 2'b00};
          req_data = 32'h0;
        end
      endcase
    end else if (op_sel == OP_BREAKPOINT) begin
      req_kind = EXT_BREAKPOINT_OP_ACK;
      req_addr = imm;
      req_data = 32'h0;
    end
  end

  assign ev_trap = (do_exec & need_trap)
                   | (ack_in & ~exc & (op_sel == OP_BREAKPOINT));
  assign ev_done = (do_exec & ~need_trap
                    & ~(op_sel inside {OP_BREAKPOINT, OP_BRANCH_SUB}))
                   | (ack_in & (exc ? step == 2'h3
                                    : op_sel != OP_BREAKPOINT));
  assign ev_bg = do_exec & (op_sel == OP_BACKGROUND) & bg_en;

  // wishbone slave: ack one cycle after request, unmapped reads zero
  always_comb begin
    case (I_WB_ADR)
      `IIS_R_CTRL: rdata = {20'h0, cond_sel, 3'h0, op_sel};
      `IIS_R_SRC: rdata = src;
      `IIS_R_DST: rdata = dst;
      `IIS_R_IMM: rdata = imm;
      `IIS_R_PC: rdata = pc;
      `IIS_R_USER_SP: rdata = user_stack_pointer;
      `IIS_R_SUPV_SP: rdata = supervisor_stack_pointer;
      `IIS_R_STATUS_WORD: rdata = {16'h0, status_word};
      `IIS_R_ADDR_X: rdata = addr_x;
      `IIS_R_ADDR_Y: rdata = addr_y;
      `IIS_R_VEC_BASE: rdata = vec_base;
      `IIS_R_CFG: rdata = {31'h0, bg_en};
      `IIS_R_STATE: rdata = {16'h0, vec, 5'h0, exc, O_ENTER_BACKGROUND, busy};
      `IIS_R_INT_STAT: rdata = {29'h0, int_stat};
      `IIS_R_INT_MASK: rdata = {29'h0, int_mask};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0;
    end else if (I_CE) begin
      O_WB_ACK <= I_WB_CYC & I_WB_STB & ~O_WB_ACK;
      if (I_WB_CYC & I_WB_STB & ~O_WB_ACK) begin
        O_WB_DAT <= rdata;
      end
    end
  end

  // operand setup written only by software
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      op_sel <= OP_ADD_IMM;
      cond_sel <= 4'h0;
      src <= 32'h0;
      imm <= 32'h0;
      vec_base <= 32'h0;
      bg_en <= 1'b0;
    end else if (wr_ok) begin
      case (I_WB_ADR)
        `IIS_R_CTRL: begin
          if (I_WB_SEL[0]) op_sel <= iis_op_t'(I_WB_DAT[4:0]);
          if (I_WB_SEL[1]) cond_sel <= I_WB_DAT[`IIS_CTRL_COND+:4];
        end
        `IIS_R_SRC: src <= wmerge(src, I_WB_SEL);
        `IIS_R_IMM: imm <= wmerge(imm, I_WB_SEL);
        `IIS_R_VEC_BASE: vec_base <= wmerge(vec_base, I_WB_SEL);
        `IIS_R_CFG: if (I_WB_SEL[0]) bg_en <= I_WB_DAT[`IIS_CFG_BG_EN];
        default: bg_en <= bg_en;
      endcase
    end
  end

  // destination and address registers, written back at execute
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      dst <= 32'h0;
      addr_x <= 32'h0;
      addr_y <= 32'h0;
    end else if (do_exec) begin
      dst <= next_dst;
      if (op_sel == OP_ADD_EXT_MEM) begin
        addr_x <= addr_x - `IIS_STEP_L;
        addr_y <= addr_y - `IIS_STEP_L;
      end else if (op_sel == OP_DEC_ADD_MEM) begin
        addr_x <= addr_x - `IIS_STEP_B;
        addr_y <= addr_y - `IIS_STEP_B;
      end else if (op_sel == OP_MEM_COMPARE) begin
        addr_x <= addr_x + `IIS_STEP_L;
        addr_y <= addr_y + `IIS_STEP_L;
      end
    end else if (wr_ok) begin
      if (I_WB_ADR == `IIS_R_DST) dst <= wmerge(dst, I_WB_SEL);
      if (I_WB_ADR == `IIS_R_ADDR_X) addr_x <= wmerge(addr_x, I_WB_SEL);
      if (I_WB_ADR == `IIS_R_ADDR_Y) addr_y <= wmerge(addr_y, I_WB_SEL);
    end
  end

  // program counter, status word and both stack pointers
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      pc <= 32'h0;
      status_word <= `IIS_SW_RST;
      user_stack_pointer <= 32'h0;
      supervisor_stack_pointer <= 32'h0;
    end else if (do_exec) begin
      if (op_sel == OP_AND_STATUS) begin
        if (sbit) status_word <= status_word & imm[15:0];
      end else begin
        status_word[4:0] <= next_cc;
      end
      if ((op_sel == OP_BRANCH_CC & cc_true) | (op_sel == OP_BRANCH)) begin
        pc <= pc + imm;
      end
    end else if (ack_in) begin
      if (exc & (step == 2'h3)) begin
        pc <= I_EXT_DATA;
        status_word[`IIS_SW_S] <= 1'b1;
      end else if (exc) begin
        supervisor_stack_pointer <= O_EXT_ADDR;
      end else if (op_sel == OP_BRANCH_SUB) begin
        pc <= pc + imm;
        if (sbit) supervisor_stack_pointer <= O_EXT_ADDR;
        else user_stack_pointer <= O_EXT_ADDR;
      end
    end else if (wr_ok) begin
      case (I_WB_ADR)
        `IIS_R_PC: pc <= wmerge(pc, I_WB_SEL);
        `IIS_R_STATUS_WORD: status_word <= 16'(wmerge({16'h0, status_word},
                                                     I_WB_SEL));
        `IIS_R_USER_SP: user_stack_pointer <= wmerge(user_stack_pointer,
                                                      I_WB_SEL);
        `IIS_R_SUPV_SP: supervisor_stack_pointer <= wmerge(
                          supervisor_stack_pointer, I_WB_SEL);
        default: pc <= pc;
      endcase
    end
  end

  // sequencer; the outgoing request holds until the partner acks it
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      exc <= 1'b0;
      step <= 2'h0;
      vec <= 8'h0;
      O_EXT_REQ <= 1'b0;
      O_EXT_KIND <= 2'h0;
      O_EXT_ADDR <= 32'h0;
      O_EXT_DATA <= 32'h0;
    end else if (I_CE) begin
      case (state)
        ST_IDLE: if (go) state <= ST_EXEC;
        ST_EXEC: begin
          if (need_trap) begin
            exc <= 1'b1;
            step <= 2'h0;
            vec <= trap_vec;
            state <= ST_ISSUE;
          end else if (op_sel inside {OP_BREAKPOINT, OP_BRANCH_SUB}) begin
            state <= ST_ISSUE;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_ISSUE: begin
          O_EXT_REQ <= 1'b1;
          O_EXT_KIND <= req_kind;
          O_EXT_ADDR <= req_addr;
          O_EXT_DATA <= req_data;
          state <= ST_WAIT;
        end
        ST_WAIT: if (I_EXT_ACK) begin
          O_EXT_REQ <= 1'b0;
          if (~exc & (op_sel == OP_BREAKPOINT)) begin
            exc <= 1'b1;
            step <= 2'h0;
            vec <= `IIS_VEC_ILLEGAL;
            state <= ST_ISSUE;
          end else if (exc & (step != 2'h3)) begin
            step <= step + 2'h1;
            state <= ST_ISSUE;
          end else begin
            exc <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // background mode holds until software asks to leave
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      O_ENTER_BACKGROUND <= 1'b0;
    end else if (ev_bg) begin
      O_ENTER_BACKGROUND <= 1'b1;
    end else if (wr_ok & (I_WB_ADR == `IIS_R_CFG) & I_WB_SEL[0]
                 & I_WB_DAT[`IIS_CFG_BG_EXIT]) begin
      O_ENTER_BACKGROUND <= 1'b0;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge I_REF_CLK) begin
    if (I_RESET) begin
      int_stat <= 3'h0;
      int_mask <= 3'h0;
      O_IRQ <= 1'b0;
    end else if (I_CE) begin
      int_stat <= (int_stat & ~({3{wr_en & I_WB_SEL[0]
                                   & (I_WB_ADR == `IIS_R_INT_STAT)}}
                                & I_WB_DAT[2:0]))
                  | {ev_bg, ev_trap, ev_done};
      if (wr_en & I_WB_SEL[0] & (I_WB_ADR == `IIS_R_INT_MASK)) begin
        int_mask <= I_WB_DAT[2:0];
      end
      O_IRQ <= |(int_stat & int_mask);
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  property p_cc_zero;
    do_exec & (op_sel == OP_ADD_IMM) |=>
      status_word[`IIS_CC_Z] == (dst == 32'h0)
      && status_word[`IIS_CC_X] == status_word[`IIS_CC_C];
  endproperty
  a_cc_zero: assert property (p_cc_zero)
    else $error("zero or extend flag wrong after add");
  property p_add_imm;
    do_exec & (op_sel == OP_ADD_QUICK) |=> dst == $past(imm) + $past(dst);
  endproperty
  a_add_imm: assert property (p_add_imm)
    else $error("quick add result wrong");
  property p_add_ext;
    do_exec & (op_sel == OP_ADD_EXT_MEM) |=>
      dst == $past(src) + $past(dst) + {31'h0, $past(status_word[4])}
      && addr_x == $past(addr_x) - 32'h4;
  endproperty
  a_add_ext: assert property (p_add_ext)
    else $error("extended add or predecrement wrong");
  property p_priv;
    do_exec & (op_sel == OP_AND_STATUS) & ~sbit |=>
      status_word == $past(status_word) && exc && vec == `IIS_VEC_PRIV;
  endproperty
  a_priv: assert property (p_priv)
    else $error("user status write not trapped cleanly");
  property p_branch;
    do_exec & (op_sel == OP_BRANCH_CC) |=>
      pc == ($past(cc_true) ? $past(pc) + $past(imm) : $past(pc));
  endproperty
  a_branch: assert property (p_branch)
    else $error("conditional branch target wrong");
  property p_bit_chg;
    do_exec & (op_sel == OP_BIT_CHG) |=> dst == ($past(dst) ^ $past(bmask))
      && status_word[`IIS_CC_Z] == ~$past(bitv);
  endproperty
  a_bit_chg: assert property (p_bit_chg)
    else $error("bit change wrong");
  property p_bit_clr;
    do_exec & (op_sel == OP_BIT_CLR) |=> (dst & $past(bmask)) == 32'h0;
  endproperty
  a_bit_clr: assert property (p_bit_clr)
    else $error("bit clear left bit set");
  property p_breakpoint_op;
    ack_in & ~exc & (op_sel == OP_BREAKPOINT) |=>
      exc && vec == `IIS_VEC_ILLEGAL && state == ST_ISSUE;
  endproperty
  a_breakpoint_op: assert property (p_breakpoint_op)
    else $error("breakpoint did not trap as illegal");
  property p_sub_push;
    (state == ST_ISSUE) & I_CE & ~exc & (op_sel == OP_BRANCH_SUB) |=>
      O_EXT_REQ && O_EXT_ADDR == $past(sp_act) - 32'h4
      && O_EXT_DATA == $past(pc);
  endproperty
  a_sub_push: assert property (p_sub_push)
    else $error("subroutine push address or data wrong");
  property p_bound;
    do_exec & (op_sel == OP_BOUND) & dst[31] |=> exc;
  endproperty
  a_bound: assert property (p_bound)
    else $error("negative register did not trap");
  property p_compare;
    do_exec & (op_sel == OP_COMPARE) |=> dst == $past(dst);
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare altered destination");
  c_trap: cover property (ev_trap);
  c_sub: cover property (ack_in & ~exc & (op_sel == OP_BRANCH_SUB));
  c_bg: cover property (ev_bg);
endmodule

// ### logic/iis_defines.svh
// register offsets, field positions, reset values and step sizes
`ifndef IIS_DEFINES_SVH
`define IIS_DEFINES_SVH
`define IIS_R_CTRL 8'h00
`define IIS_R_SRC 8'h04
`define IIS_R_DST 8'h08
`define IIS_R_IMM 8'h0c
`define IIS_R_PC 8'h10
`define IIS_R_USER_SP 8'h14
`define IIS_R_SUPV_SP 8'h18
`define IIS_R_STATUS_WORD 8'h1c
`define IIS_R_ADDR_X 8'h20
`define IIS_R_ADDR_Y 8'h24
`define IIS_R_VEC_BASE 8'h28
`define IIS_R_CFG 8'h2c
`define IIS_R_STATE 8'h30
`define IIS_R_INT_STAT 8'h34
`define IIS_R_INT_MASK 8'h38
`define IIS_CTRL_GO 16
`define IIS_CTRL_COND 8
`define IIS_CFG_BG_EN 0
`define IIS_CFG_BG_EXIT 1
`define IIS_ST_BUSY 0
`define IIS_ST_BG 1
`define IIS_ST_EXC 2
`define IIS_ST_VEC 8
`define IIS_INT_DONE 0
`define IIS_INT_TRAP 1
`define IIS_INT_BG 2
`define IIS_CC_X 4
`define IIS_CC_N 3
`define IIS_CC_Z 2
`define IIS_CC_V 1
`define IIS_CC_C 0
`define IIS_SW_S 13
`define IIS_SW_RST 16'h2000
`define IIS_FMT 4'h0
`define IIS_VEC_ILLEGAL 8'h04
`define IIS_VEC_BOUND 8'h06
`define IIS_VEC_PRIV 8'h08
`define IIS_STEP_L 32'h4
`define IIS_STEP_W 32'h2
`define IIS_STEP_B 32'h1
`endif

// ### logic/iis_pkg.sv
// shared types of the integer instruction execution unit
package iis_pkg;
  typedef enum logic [4:0] {
    OP_ADD_IMM = 5'h00, OP_ADD_QUICK = 5'h01, OP_ADD_EXT = 5'h02,
    OP_ADD_EXT_MEM = 5'h03, OP_DEC_ADD = 5'h04, OP_DEC_ADD_MEM = 5'h05,
    OP_AND_STATUS = 5'h06, OP_BRANCH_CC = 5'h07, OP_BRANCH = 5'h08,
    OP_BIT_CHG = 5'h09, OP_BIT_CLR = 5'h0a, OP_BIT_SET = 5'h0b,
    OP_BIT_TEST = 5'h0c, OP_BACKGROUND = 5'h0d, OP_BREAKPOINT = 5'h0e,
    OP_BRANCH_SUB = 5'h0f, OP_BOUND = 5'h10, OP_BOUND2 = 5'h11,
    OP_COMPARE = 5'h12, OP_MEM_COMPARE = 5'h13
  } iis_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_ISSUE = 2'h2, ST_WAIT = 2'h3
  } iis_state_t;
  typedef enum logic [1:0] {
    EXT_PUSH_W = 2'h0, EXT_PUSH_L = 2'h1, EXT_VEC_RD = 2'h2,
    EXT_BREAKPOINT_OP_ACK = 2'h3
  } iis_ext_t;
  typedef enum logic [3:0] {
    CC_T = 4'h0, CC_F = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3,
    CC_CC = 4'h4, CC_CS = 4'h5, CC_NE = 4'h6, CC_EQ = 4'h7,
    CC_VC = 4'h8, CC_VS = 4'h9, CC_PL = 4'ha, CC_MI = 4'hb,
    CC_GE = 4'hc, CC_LT = 4'hd, CC_GT = 4'he, CC_LE = 4'hf
  } iis_cond_t;
endpackage

// ### test/iis_ext_model.sv
// bus partner model: acks core cycles, serves vector reads
`timescale 1ns/1ns
module iis_ext_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_wait,
  input wire logic i_req,
  input wire logic [1:0] i_kind,
  input wire logic [31:0] i_addr,
  output logic o_ack,
  output logic [31:0] o_data
);
  logic [1:0] cnt;
  // one ack pulse after i_wait stall cycles, breakpoint cycles too
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_req || o_ack) begin
      cnt <= 2'h0;
      o_ack <= 1'b0;
    end else if (cnt == i_wait) begin
      o_ack <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  // vector words follow the address; idle bus toggles so stale data shows
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data <= 32'h0;
    end else if (i_req && i_kind == 2'h2 && !o_ack) begin
      o_data <= i_addr ^ 32'h1000;
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule

// ### test/integer_instruction_semantics_tb.sv
// self-checking bench: register tasks and operation sequences
`timescale 1ns/1ns
module integer_instruction_semantics_tb;
  import iis_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, req, eack, bg, irq;
  logic [7:0] adr = 8'h0;
  logic [31:0] wd = 32'h0, rdat, ea, ed, erd, q;
  logic [1:0] kind, wt = 2'h0;
  int errors = 0, n_tests = 0;
  iis_op_t bop [4] = '{OP_BIT_CHG, OP_BIT_SET, OP_BIT_CLR, OP_BIT_TEST};
  logic [31:0] bim [4] = '{32'h0, 32'h4, 32'h24, 32'h3f};
  logic [31:0] bdt [4] = '{32'h0, 32'h10, 32'h0, 32'h0};
  iis_core dut_u (.I_REF_CLK(clk), .I_RESET(rst), .I_CE(1'b1),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(4'hf), .I_WB_DAT(wd), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .O_EXT_REQ(req), .O_EXT_KIND(kind), .O_EXT_ADDR(ea), .O_EXT_DATA(ed),
    .I_EXT_ACK(eack), .I_EXT_DATA(erd), .O_ENTER_BACKGROUND(bg), .O_IRQ(irq));
  iis_ext_model ext_u (.i_clk(clk), .i_rst(rst), .i_wait(wt), .i_req(req),
    .i_kind(kind), .i_addr(ea), .o_ack(eack), .o_data(erd));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  // classic cycle: hold until ack, one idle cycle after release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ld(input logic [31:0] s, d, i);
    wb(1'b1, 8'h04, s);
    wb(1'b1, 8'h08, d);
    wb(1'b1, 8'h0c, i);
  endtask
  // start an operation and poll busy; the watchdog bounds a hang
  task automatic run(input iis_op_t o, input logic [3:0] c);
    wb(1'b1, 8'h00, {15'h0, 1'b1, 4'h0, c, 3'h0, o});
    do wb(1'b0, 8'h30, 32'h0); while (q[0] !== 1'b0);
  endtask
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h1c, 32'h2000);
    rd(8'h3c, 32'h0);
    wb(1'b1, 8'h38, 32'h2);
    wb(1'b1, 8'h28, 32'h400);
    wb(1'b1, 8'h18, 32'h1000);
    ld(32'h0, 32'h5, 32'h7);
    run(OP_ADD_IMM, 4'h0);
    rd(8'h08, 32'hc);
    ld(32'h0, 32'hffffffff, 32'h1);
    run(OP_ADD_QUICK, 4'h0);
    rd(8'h08, 32'h0);
    rd(8'h1c, 32'h2015);
    ld(32'h1, 32'h2, 32'h0);
    run(OP_ADD_EXT, 4'h0);
    rd(8'h08, 32'h4);
    ld(32'h19, 32'h28, 32'h0);
    run(OP_DEC_ADD, 4'h0);
    rd(8'h08, 32'h47);
    wb(1'b1, 8'h20, 32'h40);
    run(OP_ADD_EXT_MEM, 4'h0);
    run(OP_DEC_ADD_MEM, 4'h0);
    run(OP_MEM_COMPARE, 4'h0);
    rd(8'h20, 32'h3f);
    ld(32'h0, 32'h1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 8'h0c, bim[i]);
      run(bop[i], 4'h0);
      rd(8'h08, bdt[i]);
      wb(1'b0, 8'h1c, 32'h0);
      chk({31'h0, q[2]}, 32'(i % 2));
    end
    ld(32'h9, 32'h7, 32'h10);
    run(OP_COMPARE, 4'h0);
    rd(8'h08, 32'h7);
    wb(1'b1, 8'h10, 32'h100);
    run(OP_BRANCH_CC, CC_EQ);
    rd(8'h10, 32'h100);
    run(OP_BRANCH_CC, CC_NE);
    rd(8'h10, 32'h110);
    ld(32'h0, 32'h0, 32'h20);
    run(OP_BRANCH_SUB, 4'h0);
    rd(8'h10, 32'h130);
    rd(8'h18, 32'hffc);
    ld(32'h4, 32'h4, 32'h0);
    run(OP_BOUND, 4'h0);
    rd(8'h10, 32'h130);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h08, 32'h5);
    run(OP_BOUND, 4'h0);
    rd(8'h10, 32'h1418);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h34, 32'h7);
    wt <= 2'h2;
    wb(1'b1, 8'h10, 32'h0);
    ld(32'h0, 32'ha, 32'h5);
    chk({31'h0, irq}, 32'h0);
    run(OP_BOUND2, 4'h0);
    rd(8'h10, 32'h1418);
    rd(8'h18, 32'hfec);
    wb(1'b1, 8'h1c, 32'h0);
    run(OP_AND_STATUS, 4'h0);
    rd(8'h10, 32'h1420);
    rd(8'h1c, 32'h2000);
    wb(1'b1, 8'h1c, 32'h201f);
    wb(1'b1, 8'h0c, 32'h2004);
    run(OP_AND_STATUS, 4'h0);
    rd(8'h1c, 32'h2004);
    run(OP_BREAKPOINT, 4'h0);
    rd(8'h10, 32'h1410);
    rd(8'h18, 32'hfdc);
    run(OP_BRANCH, 4'h0);
    rd(8'h10, 32'h3414);
    // background disabled: full illegal frame, eight bytes below
    run(OP_BACKGROUND, 4'h0);
    rd(8'h18, 32'hfd4);
    rd(8'h10, 32'h1410);
    wb(1'b1, 8'h2c, 32'h1);
    run(OP_BACKGROUND, 4'h0);
    chk({31'h0, bg}, 32'h1);
    wb(1'b1, 8'h2c, 32'h2);
    chk({31'h0, bg}, 32'h0);
    // negative register traps whatever the source holds
    ld(32'h4, 32'hffffffff, 32'h0);
    run(OP_BOUND, 4'h0);
    rd(8'h18, 32'hfcc);
    report_and_stop();
  end
endmodule
